/* File: design/eqc_handler.sv */
/*
  Escape query command handler: takes request frames a byte at a time,
  checks them and answers random-number and version queries.
  Assumes the host keeps to the frame format; bad frames are dropped.
*/
module eqc_handler import eqc_pkg::*; #(
  parameter logic [39:0] FW_VERSION = VERSION_DEF
) (
  // Clock and reset
  input  wire logic           core_clk_i,
  input  wire logic           rst_i,
  // Request byte stream
  input  wire logic [7:0]     in_data_i,
  input  wire logic           in_valid_i,
  output logic                in_ready_o,
  // Reply byte stream
  output logic [7:0]          out_data_o,
  output logic                out_last_o,
  output logic                out_valid_o,
  input  wire logic           out_ready_i,
  // Random source and status
  input  wire logic [7:0]     entropy_i,
  output logic [127:0]        challenge_o,
  output logic                challenge_valid_o,
  output logic                frame_err_o
);
  eqc_state_e  state_reg, state_next;
  logic [15:0] count_reg, count_next, len_reg, len_next;
  logic [7:0]  pos_reg, pos_next, op_reg, op_next, plen_reg, plen_next;
  logic [7:0]  xor_reg, xor_next, tx_xor_reg, tx_xor_next;
  logic [4:0]  tx_idx_reg, tx_idx_next;
  logic        err_reg, err_next, good_pulse;
  logic [31:0] lfsr_reg, lfsr_next;
  logic [7:0]  chal_reg [RND_BYTES], chal_next [RND_BYTES];
  logic        chal_ok_reg, chal_ok_next;
  logic        in_hs, push, push_last, is_rnd;
  logic [7:0]  push_data;
  logic [4:0]  last_idx;
  logic [7:0]  buf_data_reg [BUF_DEPTH], buf_data_next [BUF_DEPTH];
  logic        buf_last_reg [BUF_DEPTH], buf_last_next [BUF_DEPTH];
  logic        wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0]  fill_reg, fill_next;
  logic        buf_full, pop;

  assign in_ready_o  = (state_reg != ST_REPLY);
  assign in_hs       = in_valid_i && in_ready_o;
  assign is_rnd      = (op_reg == OP_RANDOM);
  assign last_idx    = is_rnd ? 5'(RND_COUNT + 16'h2) : 5'(VER_COUNT + 16'h2);
  assign buf_full    = (fill_reg == 2'(BUF_DEPTH));
  assign push        = (state_reg == ST_REPLY) && !buf_full;
  assign push_last   = (tx_idx_reg == last_idx);

  // Reply byte for the current index
  always_comb begin
    unique case (tx_idx_reg)
      5'h00:   push_data = REPLY_TYPE;
      5'h01:   push_data = is_rnd ? RND_COUNT[7:0] : VER_COUNT[7:0];
      5'h02:   push_data = is_rnd ? RND_COUNT[15:8] : VER_COUNT[15:8];
      5'h03:   push_data = op_reg | REPLY_BIT;
      5'h04:   push_data = is_rnd ? RND_PAYLOAD : VER_PAYLOAD;
      default: begin
        if (push_last) begin
          push_data = tx_xor_reg;
        end else if (is_rnd) begin
          push_data = lfsr_reg[7:0];
        end else begin
          push_data = FW_VERSION[8*(4 - (int'(tx_idx_reg) - 5)) +: 8];
        end
      end
    endcase
  end

  // Request parser and reply sequencer
  always_comb begin
    state_next  = state_reg;
    count_next  = count_reg;
    len_next    = len_reg;
    pos_next    = pos_reg;
    op_next     = op_reg;
    plen_next   = plen_reg;
    xor_next    = xor_reg;
    tx_idx_next = tx_idx_reg;
    tx_xor_next = tx_xor_reg;
    err_next    = 1'b0;
    good_pulse  = 1'b0;
    unique case (state_reg)
      ST_TYPE: begin
        if (in_hs && in_data_i == REQ_TYPE) begin
          xor_next   = in_data_i;
          state_next = ST_CNT_LO;
        end else if (in_hs) begin
          err_next = 1'b1;
        end
      end
      ST_CNT_LO: begin
        if (in_hs) begin
          len_next[7:0] = in_data_i;
          xor_next      = xor_reg ^ in_data_i;
          state_next    = ST_CNT_HI;
        end
      end
      ST_CNT_HI: begin
        if (in_hs) begin
          len_next[15:8] = in_data_i;
          count_next     = {in_data_i, len_reg[7:0]};
          xor_next       = xor_reg ^ in_data_i;
          pos_next       = POS_OPCODE;
          state_next     = ({in_data_i, len_reg[7:0]} == 16'h0) ? ST_TYPE : ST_BODY;
          err_next       = ({in_data_i, len_reg[7:0]} == 16'h0);
        end
      end
      ST_BODY: begin
        if (in_hs) begin
          xor_next   = xor_reg ^ in_data_i;
          count_next = count_reg - 16'h1;
          pos_next   = (pos_reg == 8'hff) ? pos_reg : pos_reg + 8'h1;
          if (pos_reg == POS_OPCODE) begin
            op_next = in_data_i;
          end
          if (pos_reg == POS_PAYLOAD_CNT) begin
            plen_next = in_data_i;
          end
          if (count_reg == 16'h1) begin
            if ((xor_reg ^ in_data_i) == 8'h0 && len_reg == REQ_COUNT
                && plen_reg == REQ_PAYLOAD
                && (op_reg == OP_RANDOM || op_reg == OP_VERSION)) begin
              good_pulse  = 1'b1;
              tx_idx_next = 5'h0;
              tx_xor_next = 8'h0;
              state_next  = ST_REPLY;
            end else begin
              err_next   = 1'b1;
              state_next = ST_TYPE;
            end
          end
        end
      end
      ST_REPLY: begin
        if (push) begin
          tx_xor_next = tx_xor_reg ^ push_data;
          tx_idx_next = tx_idx_reg + 5'h1;
          if (push_last) begin
            state_next = ST_TYPE;
          end
        end
      end
    endcase
  end

  // Random source and kept challenge
  always_comb begin
    lfsr_next = (lfsr_reg >> 1) ^ (lfsr_reg[0] ? LFSR_POLY : 32'h0) ^ {24'h0, entropy_i};
    if (lfsr_next == 32'h0) begin
      lfsr_next = LFSR_SEED;
    end
    chal_next    = chal_reg;
    chal_ok_next = chal_ok_reg;
    if (push && is_rnd && tx_idx_reg >= POS_DATA && !push_last) begin
      chal_next[4'(tx_idx_reg - POS_DATA)] = push_data;
      chal_ok_next = 1'b0;
    end
    if (push && is_rnd && push_last) begin
      chal_ok_next = 1'b1;
    end
  end

  // Two-entry reply buffer
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (fill_reg != 2'h0);
  assign out_data_o  = buf_data_reg[rd_ptr_reg];
  assign out_last_o  = buf_last_reg[rd_ptr_reg];
  always_comb begin
    buf_data_next = buf_data_reg;
    buf_last_next = buf_last_reg;
    wr_ptr_next   = wr_ptr_reg;
    rd_ptr_next   = rd_ptr_reg;
    fill_next     = fill_reg;
    if (push) begin
      buf_data_next[wr_ptr_reg] = push_data;
      buf_last_next[wr_ptr_reg] = push_last;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    fill_next = fill_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_TYPE;
      count_reg   <= 16'h0;
      len_reg     <= 16'h0;
      pos_reg     <= 8'h0;
      op_reg      <= 8'h0;
      plen_reg    <= 8'h0;
      xor_reg     <= 8'h0;
      tx_idx_reg  <= 5'h0;
      tx_xor_reg  <= 8'h0;
      err_reg     <= 1'b0;
      lfsr_reg    <= LFSR_SEED;
      chal_ok_reg <= 1'b0;
      wr_ptr_reg  <= 1'b0;
      rd_ptr_reg  <= 1'b0;
      fill_reg    <= 2'h0;
      for (int i = 0; i < RND_BYTES; i++) begin
        chal_reg[i] <= 8'h0;
      end
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_data_reg[i] <= 8'h0;
        buf_last_reg[i] <= 1'b0;
      end
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      len_reg      <= len_next;
      pos_reg      <= pos_next;
      op_reg       <= op_next;
      plen_reg     <= plen_next;
      xor_reg      <= xor_next;
      tx_idx_reg   <= tx_idx_next;
      tx_xor_reg   <= tx_xor_next;
      err_reg      <= err_next;
      lfsr_reg     <= lfsr_next;
      chal_ok_reg  <= chal_ok_next;
      chal_reg     <= chal_next;
      wr_ptr_reg   <= wr_ptr_next;
      rd_ptr_reg   <= rd_ptr_next;
      fill_reg     <= fill_next;
      buf_data_reg <= buf_data_next;
      buf_last_reg <= buf_last_next;
    end
  end

  assign frame_err_o       = err_reg;
  assign challenge_valid_o = chal_ok_reg;
  for (genvar g = 0; g < RND_BYTES; g++) begin : g_chal
    assign challenge_o[8*g +: 8] = chal_reg[g];
  end

  // Checking helpers: position and running XOR of the outgoing frame
  logic [4:0] mon_pos;
  logic [7:0] mon_xor, mon_op, mon_cnt;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mon_pos <= 5'h0;
      mon_xor <= 8'h0;
      mon_op  <= 8'h0;
      mon_cnt <= 8'h0;
    end else if (pop) begin
      mon_pos <= out_last_o ? 5'h0 : mon_pos + 5'h1;
      mon_xor <= out_last_o ? 8'h0 : mon_xor ^ out_data_o;
      if (mon_pos == 5'h3) mon_op <= out_data_o;
      if (mon_pos == 5'h1) mon_cnt <= out_data_o;
    end
  end

  sequence s_good_request;
    state_reg == ST_BODY && in_hs && count_reg == 16'h1 && good_pulse;
  endsequence
  sequence s_reply_open;
    out_valid_o && mon_pos == 5'h0 && out_data_o == REPLY_TYPE;
  endsequence

  a_reply_type_byte: assert property (@(posedge core_clk_i) disable iff (rst_i)
    out_valid_o && mon_pos == 5'h0 |-> out_data_o == REPLY_TYPE) else $error("reply type wrong");
  a_bad_type_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_TYPE && in_hs && in_data_i != REQ_TYPE |=> state_reg == ST_TYPE && frame_err_o)
    else $error("bad type not dropped");
  a_count_high_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    out_valid_o && mon_pos == 5'h2 |-> out_data_o == 8'h0) else $error("count high byte wrong");
  a_count_covers_tail: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pop && out_last_o |-> 8'(mon_pos) == mon_cnt + 8'h2) else $error("frame length mismatch");
  a_check_byte_xor: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pop && out_last_o |-> (mon_xor ^ out_data_o) == 8'h0) else $error("reply checksum wrong");
  a_query_no_payload: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == ST_BODY && in_hs && count_reg == 16'h1 && plen_reg != REQ_PAYLOAD
    |=> state_reg == ST_TYPE && frame_err_o) else $error("payload count accepted");
  a_query_answered: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_good_request |-> ##[1:4] s_reply_open) else $error("no reply to query");
  a_random_shape: assert property (@(posedge core_clk_i) disable iff (rst_i)
    out_valid_o && mon_pos == 5'h4 && mon_op == 8'h83 |-> out_data_o == RND_PAYLOAD)
    else $error("random payload count wrong");
  a_challenge_kept: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg != ST_REPLY |=> $stable(challenge_o)) else $error("challenge changed");
  a_version_op: assert property (@(posedge core_clk_i) disable iff (rst_i)
    good_pulse && op_reg == OP_VERSION |=> state_reg == ST_REPLY && !is_rnd) else $error("version not taken");
  a_version_text: assert property (@(posedge core_clk_i) disable iff (rst_i)
    out_valid_o && mon_pos == 5'h5 && mon_op == 8'h84 |-> out_data_o == 8'h56) else $error("version text wrong");
  a_opcode_bit_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    out_valid_o && mon_pos == 5'h3 |-> out_data_o == (op_reg | REPLY_BIT)) else $error("reply opcode wrong");
endmodule

/* File: pkg/eqc_pkg.sv */
/*
  Constants and types for the escape query command handler.
  Assumes a byte stream in each direction, one clock, synchronous reset.
*/
// Functional notes
// - Requests start 6Bh, replies start 15h
// - Bytes 1-2: count after them, low first
// - Last byte is XOR of all before
// - Byte 4 payload count, 00h for queries
// - Opcode 03h, count 0003: random request
// - Random reply: 83h, count 0013, 16 bytes
// - Keep returned random value as challenge
// - Opcode 04h, count 0003: version request
// - Version reply: 84h, count 0008, "Vd.dd"
package eqc_pkg;
  localparam logic [7:0]  REQ_TYPE        = 8'h6b;
  localparam logic [7:0]  REPLY_TYPE      = 8'h15;
  localparam logic [7:0]  OP_RANDOM       = 8'h03;
  localparam logic [7:0]  OP_VERSION      = 8'h04;
  localparam logic [7:0]  REPLY_BIT       = 8'h80;
  localparam logic [15:0] REQ_COUNT       = 16'h0003;
  localparam logic [7:0]  REQ_PAYLOAD     = 8'h00;
  localparam logic [15:0] RND_COUNT       = 16'h0013;
  localparam logic [7:0]  RND_PAYLOAD     = 8'h10;
  localparam logic [15:0] VER_COUNT       = 16'h0008;
  localparam logic [7:0]  VER_PAYLOAD     = 8'h05;
  localparam logic [7:0]  POS_OPCODE      = 8'h03;
  localparam logic [7:0]  POS_PAYLOAD_CNT = 8'h04;
  localparam logic [4:0]  POS_DATA        = 5'h05;
  localparam logic [39:0] VERSION_DEF     = 40'h56_31_2e_30_30;
  localparam logic [31:0] LFSR_SEED       = 32'h1234_5679;
  localparam logic [31:0] LFSR_POLY       = 32'h8020_0003;
  localparam int          RND_BYTES       = 16;
  localparam int          BUF_DEPTH       = 2;
  localparam int          REPLY_TIMEOUT   = 30;

  typedef enum logic [2:0] {
    ST_TYPE,
    ST_CNT_LO,
    ST_CNT_HI,
    ST_BODY,
    ST_REPLY
  } eqc_state_e;
endpackage

/* File: testbench/eqc_handler_tb_top.sv */
/*
  Testbench for the escape query handler: good and bad query frames.
  Assumes the host model drives and collects both byte streams.
*/
module eqc_handler_tb_top import eqc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk;
  logic         rst;
  logic         slow;
  logic [7:0]   ent;
  logic [7:0]   rq_d;
  logic         rq_v;
  logic         rq_r;
  logic [7:0]   rp_d;
  logic         rp_l;
  logic         rp_v;
  logic         rp_r;
  logic [127:0] chal;
  logic         chal_v;
  logic         ferr;
  int           error_cnt = 0;
  int           tests_run = 0;
  int           errs = 0;

  eqc_handler u_eqc_handler (.core_clk_i(clk), .rst_i(rst), .in_data_i(rq_d), .in_valid_i(rq_v),
    .in_ready_o(rq_r), .out_data_o(rp_d), .out_last_o(rp_l), .out_valid_o(rp_v), .out_ready_i(rp_r),
    .entropy_i(ent), .challenge_o(chal), .challenge_valid_o(chal_v), .frame_err_o(ferr));
  eqc_host_model u_eqc_host_model (.clk_i(clk), .rst_i(rst), .req_data_o(rq_d), .req_valid_o(rq_v),
    .req_ready_i(rq_r), .rep_data_i(rp_d), .rep_last_i(rp_l), .rep_valid_i(rp_v), .rep_ready_o(rp_r),
    .slow_i(slow));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    ent <= rst ? 8'h00 : ent + 8'h35;
    if (ferr === 1'b1) begin
      errs++;
    end
  end

  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Waits for n bytes, then checks header, check byte and last marker
  task automatic reply(input int b, input int n, input logic [7:0] h [0:4]);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < 300 && int'(u_eqc_host_model.rx_n) < b + n; i++) begin
      @(posedge clk);
    end
    check("reply length", u_eqc_host_model.rx_n, 8'(b + n));
    for (int i = 0; i < 5; i++) begin
      check("header byte", u_eqc_host_model.rx[8'(b + i)], h[i]);
    end
    for (int i = 0; i < n; i++) begin
      x = x ^ u_eqc_host_model.rx[8'(b + i)];
    end
    check("xor of reply", x, 8'h00);
    check("last byte", u_eqc_host_model.last_n, 8'(b + n - 1));
  endtask

  task automatic t_random(input logic s);
    int b;
    b = u_eqc_host_model.rx_n;
    slow <= s;
    u_eqc_host_model.send(REQ_TYPE, 8'h03, OP_RANDOM, REQ_PAYLOAD, 8'h00);
    reply(b, 22, '{8'h15, 8'h13, 8'h00, 8'h83, 8'h10});
    for (int k = 0; k < RND_BYTES; k++) begin
      check("challenge", chal[8*k +: 8], u_eqc_host_model.rx[8'(b + 5 + k)]);
    end
    check("challenge valid", chal_v, 1'b1);
  endtask

  task automatic t_version();
    int b;
    b = u_eqc_host_model.rx_n;
    slow <= 1'b0;
    u_eqc_host_model.send(REQ_TYPE, 8'h03, OP_VERSION, REQ_PAYLOAD, 8'h00);
    reply(b, 11, '{8'h15, 8'h08, 8'h00, 8'h84, 8'h05});
    for (int k = 0; k < 5; k++) begin
      check("version", u_eqc_host_model.rx[8'(b + 5 + k)], VERSION_DEF[39 - 8*k -: 8]);
    end
  endtask

  // Wrong type, corrupt check byte, unanswered opcode, nonzero payload count
  task automatic t_bad();
    logic [7:0] c [0:3][0:4];
    logic [127:0] keep;
    int b;
    int e;
    c = '{'{8'h00, 8'h03, 8'h04, 8'h00, 8'h00}, '{8'h6b, 8'h03, 8'h03, 8'h00, 8'h01},
          '{8'h6b, 8'h03, 8'h02, 8'h00, 8'h00}, '{8'h6b, 8'h03, 8'h03, 8'h01, 8'h00}};
    keep = chal;
    for (int i = 0; i < 4; i++) begin
      b = u_eqc_host_model.rx_n;
      e = errs;
      u_eqc_host_model.send(c[i][0], c[i][1], c[i][2], c[i][3], c[i][4]);
      repeat (REPLY_TIMEOUT) @(posedge clk);
      check("no reply", u_eqc_host_model.rx_n, 8'(b));
      check("error pulse", 1'(errs > e), 1'b1);
    end
    check("challenge kept", chal, keep);
  endtask

  initial begin
    #100000;
    error_cnt++;
    results();
  end

  initial begin
    rst  = 1'b1;
    slow = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("ready after reset", rq_r, 1'b1);
    check("reply idle", rp_v, 1'b0);
    check("challenge reset", chal, 128'h0);
    check("challenge valid reset", chal_v, 1'b0);
    @(posedge clk);
    t_random(1'b1);
    t_random(1'b0);
    t_version();
    t_bad();
    t_version();
    results();
  end
endmodule

/* File: testbench/eqc_host_model.sv */
/*
  Host model: sends escape request frames and collects reply bytes.
  Assumes the handler's valid/ready byte streams on one clock.
*/
module eqc_host_model import eqc_pkg::*; (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Request stream
  output logic [7:0]      req_data_o,
  output logic            req_valid_o,
  input  wire logic       req_ready_i,
  // Reply stream
  input  wire logic [7:0] rep_data_i,
  input  wire logic       rep_last_i,
  input  wire logic       rep_valid_i,
  output logic            rep_ready_o,
  // Stall control
  input  wire logic       slow_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx [0:255];
  logic [7:0] rx_n;
  logic [7:0] last_n;

  initial begin
    req_data_o  = 8'h00;
    req_valid_o = 1'b0;
  end

  // Ready toggles in slow mode to stall the reply buffer
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_n        <= 8'h00;
      last_n      <= 8'h00;
      rep_ready_o <= 1'b0;
    end else begin
      rep_ready_o <= slow_i ? ~rep_ready_o : 1'b1;
      if (rep_valid_i && rep_ready_o) begin
        rx[rx_n] <= rep_data_i;
        rx_n     <= rx_n + 8'h01;
        if (rep_last_i) begin
          last_n <= rx_n;
        end
      end
    end
  end

  // Six-byte query frame; bad is folded into the check byte
  task automatic send(input logic [7:0] t, input logic [7:0] lo, input logic [7:0] op,
                      input logic [7:0] pl, input logic [7:0] bad);
    logic [7:0] f [0:5];
    f[0] = t;
    f[1] = lo;
    f[2] = 8'h00;
    f[3] = op;
    f[4] = pl;
    f[5] = f[0] ^ f[1] ^ f[2] ^ f[3] ^ f[4] ^ bad;
    for (int i = 0; i < 6; i++) begin
      req_data_o  <= f[i];
      req_valid_o <= 1'b1;
      #1;
      while (!req_ready_i) begin
        @(posedge clk_i);
        #1;
      end
      @(posedge clk_i);
    end
    req_valid_o <= 1'b0;
    req_data_o  <= ~f[5];
  endtask
endmodule
